/* File: inc/sdo_defs.svh */
`ifndef SDO_DEFS_SVH
`define SDO_DEFS_SVH

// Qualification period in microseconds
`define SDO_QUAL_TIME_US 40000
// Clock rate in kHz
`define SDO_CLK_KHZ 100000
// Cycles in one qualification period
`define SDO_QUAL_CYCLES (`SDO_QUAL_TIME_US * (`SDO_CLK_KHZ / 1000))
// Channel count and counter width
`define SDO_CHANNELS 8
`define SDO_CNT_W 22
// Reset values
`define SDO_CLEAN_RST 8'hff
`define SDO_FLAG_RST 1'b1
`define SDO_OE_RST 8'hff
`define SDO_UV_RST 1'b0
`define SDO_EN_N_RST 1'b1
`define SDO_CNT_RST 22'h000000

`endif

/* File: inc/sdo_pkg.sv */
`include "sdo_defs.svh"

package sdo_pkg;

   typedef logic [`SDO_CHANNELS-1:0] sdo_level_t;
   typedef logic [`SDO_CNT_W-1:0] sdo_count_t;

   // Bus-side pin group for the clean levels
   typedef struct packed {
      sdo_level_t level;
      sdo_level_t oe_n;
   } sdo_bus_s;

endpackage : sdo_pkg

/* File: tb/sdo_debounce_properties.sv */
`timescale 1ns/100ps
module sdo_debounce_properties #(parameter int QUAL_CYCLES = 20) (
   input logic ref_clk_i,
   input logic reset_i,
   input logic [7:0] switch_raw_i,
   input logic undervolt_i,
   input logic out_enable_n_i,
   input sdo_pkg::sdo_bus_s clean_bus_o,
   input logic state_moved_flag_n_o
);
   wire [7:0] lv = clean_bus_o.level;
   wire [7:0] oe = clean_bus_o.oe_n;
   wire f = state_moved_flag_n_o;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   a_flag_with_level: assert property ($fell(f) |-> $changed(lv)) else $error("lone flag");
   a_level_qualified:
   assert property ($changed(lv) && !$past(undervolt_i, 3) |-> ((lv ^ $past(lv)) &
      ((lv ^ $past(switch_raw_i, 4)) | (lv ^ $past(switch_raw_i, QUAL_CYCLES)))) == 0)
      else $error("early level");
   a_change_flags:
   assert property ((out_enable_n_i && !undervolt_i)[*6] ##0 $changed(lv) |-> !f)
      else $error("no flag");
   a_poll_clears: assert property ((!out_enable_n_i)[*4] |-> f) else $error("flag low");
   a_poll_drives: assert property ((!out_enable_n_i)[*4] |-> oe == 8'h00) else $error("no drive");
   a_idle_floats: assert property (out_enable_n_i[*4] |-> oe == 8'hff) else $error("driven");
   a_lockout_pass:
   assert property ((undervolt_i && $stable(switch_raw_i))[*5] |-> lv == switch_raw_i)
      else $error("not transparent");
   a_lockout_quiet: assert property (undervolt_i[*4] |-> !$fell(f)) else $error("lock flag");
   cover property ($fell(f));
   cover property ((!out_enable_n_i)[*4]);
   cover property (undervolt_i[*5]);
endmodule : sdo_debounce_properties

/* File: tb/sdo_switch_model.sv */
`timescale 1ns/100ps
// Contacts chatter at random after each move, then settle
module sdo_switch_model (
   input wire logic clk_i,
   input wire logic [7:0] goal_i,
   input wire logic [4:0] chatter_i,
   output logic [7:0] raw_o
);
   logic [4:0] left = 5'h00;
   logic [7:0] held = 8'hff;
   logic [7:0] from = 8'hff;
   initial raw_o = 8'hff;
   // Moving contacts bounce together, so they qualify in one step
   always @(posedge clk_i) begin
      held <= goal_i;
      if (goal_i !== held) begin
         left <= chatter_i;
         from <= held;
      end else if (left != 5'h00) begin
         left <= left - 5'h01;
      end
      raw_o <= (left != 5'h00 && $urandom_range(1) == 1) ? from : goal_i;
   end
endmodule : sdo_switch_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
   localparam int Q = 20;
   logic ref_clk_i = 0, reset_i = 1, uv = 0, en_n = 1, f;
   logic [7:0] goal = 8'hff, raw, v, prev = 8'hff;
   logic [4:0] chat = 5'h00;
   logic [8:0] q[$];
   sdo_pkg::sdo_bus_s bus;
   int bad_count = 0, tests_run = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   sdo_switch_model sw (.clk_i(ref_clk_i), .goal_i(goal), .chatter_i(chat), .raw_o(raw));
   sdo_debounce #(.QUAL_CYCLES(Q)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .switch_raw_i(raw), .undervolt_i(uv), .out_enable_n_i(en_n),
      .clean_bus_o(bus), .state_moved_flag_n_o(f));
   task chk(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : tick
   task wrap_up;
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   always @(negedge ref_clk_i) if (!reset_i && bus.level !== prev) begin
      chk({bus.level, f}, q.size() ? q.pop_front() : {prev, f});
      prev = bus.level;
   end
   initial begin
      void'($urandom(37));
      tick(20);
      reset_i <= 0;
      @(negedge ref_clk_i) chk({bus.level, f}, 9'h1ff);
      for (int i = 0; i < 6; i++) begin
         tick(1);
         chat <= 5'h00;
         goal <= goal ^ (8'h01 << i);
         tick(Q / 2);
         goal <= goal ^ (8'h01 << i);
         tick(Q + 4);
         v = goal ^ 8'($urandom_range(255, 1));
         q.push_back({v, 1'b0});
         chat <= 5'($urandom_range(12));
         goal <= v;
         tick(Q + 20);
         en_n <= 0;
         tick(5);
         @(negedge ref_clk_i) chk({bus.oe_n, f}, 9'h001);
         tick(1);
         en_n <= 1;
         tick(5);
         @(negedge ref_clk_i) chk({bus.oe_n, f}, 9'h1ff);
      end
      v = goal ^ 8'($urandom_range(255, 1));
      q.push_back({v, 1'b1});
      tick(1);
      chat <= 5'h00;
      uv <= 1;
      goal <= v;
      tick(8);
      @(negedge ref_clk_i) chk({bus.level, f}, {v, 1'b1});
      tick(1);
      uv <= 0;
      tick(Q + 8);
      en_n <= 0;
      tick(4);
      v = goal ^ 8'($urandom_range(255, 1));
      q.push_back({v, 1'b1});
      goal <= v;
      tick(Q + 8);
      @(negedge ref_clk_i) chk({bus.oe_n, f}, 9'h001);
      tick(1);
      chk(9'(q.size()), 9'h000);
      wrap_up();
   end
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end
endmodule : testbench
bind sdo_debounce sdo_debounce_properties #(.QUAL_CYCLES(QUAL_CYCLES)) props (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .switch_raw_i(switch_raw_i),
   .undervolt_i(undervolt_i), .out_enable_n_i(out_enable_n_i),
   .clean_bus_o(clean_bus_o), .state_moved_flag_n_o(state_moved_flag_n_o));

/* File: verilog/sdo_debounce.sv */
`timescale 1ns/100ps
`include "sdo_defs.svh"

// Summary of operation
// - Clean output holds until input stable for 40 ms.
// - Inputs sampled each clock; same level needed over many samples.
// - Sampled input equal to clean output restarts its counter.
// - Full count with input unchanged loads input into output flop.
// - Opening and closing edges are filtered identically.
// - Change flag goes low when a qualified change occurs while enable is high.
// - Change flag updates in the same cycle as the clean output.
// - Clean outputs driven only while enable low, else released.
// - Enable low clears the change flag and holds it high.
// - Below undervoltage threshold, inputs pass straight through.
module sdo_debounce #(
   parameter int unsigned QUAL_CYCLES = `SDO_QUAL_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Switch contacts and supply monitor
   input wire logic [`SDO_CHANNELS-1:0] switch_raw_i,
   input wire logic undervolt_i,
   // Processor side
   input wire logic out_enable_n_i,
   output sdo_pkg::sdo_bus_s clean_bus_o,
   output logic state_moved_flag_n_o
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Every input pin except reset_i is asynchronous to the clock, so two flops come first
   // Only the second flop of each pair feeds any logic
   sdo_pkg::sdo_level_t raw_meta;
   sdo_pkg::sdo_level_t raw_sync;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         raw_meta <= `SDO_CLEAN_RST;
         raw_sync <= `SDO_CLEAN_RST;
      end else begin
         raw_meta <= switch_raw_i;
         raw_sync <= raw_meta;
      end
   end

   // ----------------------------------------
   // Supply monitor
   // ----------------------------------------
   logic uv_meta;
   logic uv_sync;
   logic lockout;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         uv_meta <= `SDO_UV_RST;
         uv_sync <= `SDO_UV_RST;
      end else begin
         uv_meta <= undervolt_i;
         uv_sync <= uv_meta;
      end
   end

   // Lockout makes the whole stage transparent
   assign lockout = uv_sync;

   // ----------------------------------------
   // Enable synchroniser
   // ----------------------------------------
   logic en_meta;
   logic en_n_sync;
   logic poll_active;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         en_meta <= `SDO_EN_N_RST;
         en_n_sync <= `SDO_EN_N_RST;
      end else begin
         en_meta <= out_enable_n_i;
         en_n_sync <= en_meta;
      end
   end

   assign poll_active = !en_n_sync;

   // ----------------------------------------
   // Qualification counters
   // ----------------------------------------
   sdo_pkg::sdo_level_t clean_level;
   sdo_pkg::sdo_level_t differs;
   sdo_pkg::sdo_level_t load;
   sdo_pkg::sdo_count_t cnt [`SDO_CHANNELS];

   // terminal count from clock rate
   // Count width limits the period; a longer one needs a wider count
   localparam sdo_pkg::sdo_count_t TERMINAL = `SDO_CNT_W'(QUAL_CYCLES - 1);

   // compare of input and output gates counting
   assign differs = raw_sync ^ clean_level;

   for (genvar ch = 0; ch < `SDO_CHANNELS; ch++) begin : g_chan
      assign load[ch] = differs[ch] && (cnt[ch] == TERMINAL);

      // equal input restarts timing; both directions alike
      always_ff @(posedge ref_clk_i) begin
         if (reset_i) begin
            cnt[ch] <= `SDO_CNT_RST;
         end else if (!differs[ch] || load[ch] || lockout) begin
            cnt[ch] <= '0;
         end else begin
            cnt[ch] <= cnt[ch] + `SDO_CNT_W'(1);
         end
      end
   end

   // ----------------------------------------
   // Clean levels
   // ----------------------------------------
   sdo_pkg::sdo_level_t next_clean_level;

   // Counter runs only while input differs; any bounce back clears it
   // output changes only after full period; under lockout it follows input
   always_comb begin
      if (lockout) begin
         next_clean_level = raw_sync;
      end else begin
         next_clean_level = (clean_level & ~load) | (raw_sync & load);
      end
   end

   // Reset leaves every level high, as open contacts read high
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         clean_level <= `SDO_CLEAN_RST;
      end else begin
         clean_level <= next_clean_level;
      end
   end

   // ----------------------------------------
   // Change flag
   // ----------------------------------------
   logic any_load;
   logic next_flag_n;

   // any channel update is a change; none under lockout
   assign any_load = |load && !lockout;

   // Limitation: a change that qualifies during a poll raises no flag;
   // software sees it only by comparing levels on its next poll
   // flag low on qualified change; same edge as output
   // enable low clears flag and overrides a new change
   always_comb begin
      if (poll_active) begin
         next_flag_n = 1'b1;
      end else if (any_load) begin
         next_flag_n = 1'b0;
      end else begin
         next_flag_n = state_moved_flag_n_o;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_moved_flag_n_o <= `SDO_FLAG_RST;
      end else begin
         state_moved_flag_n_o <= next_flag_n;
      end
   end

   // ----------------------------------------
   // Bus drive
   // ----------------------------------------
   sdo_pkg::sdo_bus_s next_bus;

   // Level flop mirrors clean_level so the pins come straight from a flop
   always_comb begin
      next_bus.level = next_clean_level;
      next_bus.oe_n = {`SDO_CHANNELS{en_n_sync}};
   end

   // Levels are registered apart from the enables
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         clean_bus_o.level <= `SDO_CLEAN_RST;
      end else begin
         clean_bus_o.level <= next_bus.level;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         clean_bus_o.oe_n <= `SDO_OE_RST;
      end else begin
         clean_bus_o.oe_n <= next_bus.oe_n;
      end
   end

endmodule : sdo_debounce
